// *** hw/fpd_pkg.sv ***
// Notes on behaviour
// - In sleep, writes, programs and erases ignored.
// - Sleep engages only if frame ends after opcode.
// - Sleep entered within entry delay after rise.
// - Sleeping, only release opcode recognised, both widths.
// - After release, nothing accepted until exit delay.
// - Release ignored while work is in progress.
// - Parameter byte: burst, dummy count, pin function.
// - Dedicated reset pin ignores pin function bit.
// - Persistent parameter write needs write enable latch.
// - Persistent parameter write also loads volatile copy.
// - Two volatile writes: latch-gated and ungated.
// - Wrap enabled: aligned 8..64 byte burst in page.
// - Wrapped read returns to burst start at boundary.
// - Wrap disabled: address increments through whole array.
// - Low codes 0..3 linear, 4..7 bursts 8..64.
// - Wrap persists until cleared or reset; sleep reloads it from persistent copy.
// - Every read obeys wrap when bit set.
// - Drive strength bits, persistent and volatile writes.
// - Persistent extended write also loads volatile copy.
// - Parameter readback returns volatile copy only.
// - Extended readback gives progress bit, even when busy.
// - Sample on rising clock, drive on falling, MSB first.
package fpd_pkg;

    // Opcodes handled by this block
    localparam logic [7:0] OPC_ENTER_SLEEP = 8'hB9;
    localparam logic [7:0] OPC_LEAVE_SLEEP = 8'hAB;
    localparam logic [7:0] OPC_SET_PARAM_NV = 8'h65;
    localparam logic [7:0] OPC_SET_PARAM_V_WE = 8'h63;
    localparam logic [7:0] OPC_SET_PARAM_V = 8'hC0;
    localparam logic [7:0] OPC_SET_EXT_NV = 8'h85;
    localparam logic [7:0] OPC_SET_EXT_V = 8'h83;
    localparam logic [7:0] OPC_READ_PARAM = 8'h61;
    localparam logic [7:0] OPC_READ_EXT = 8'h81;

    // Frame lengths in received bits
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_WITH_DATA = 5'h10;

    // Field positions of the extended register
    localparam int EXT_ODS_LSB = 5;
    localparam int EXT_BUSY_POS = 0;

    // Reset values of volatile and persistent copies
    localparam logic [7:0] PARAM_RESET = 8'h00;
    localparam logic [2:0] ODS_RESET = 3'h0;

    // Timing, in ns, and derived clock counts
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int SLEEP_EXIT_DELAY_NS = 3000;
    // Longest time: round down
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
    // Least time: round up
    localparam int SLEEP_EXIT_CYC =
        (SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Read parameter byte layout
    typedef struct packed {
        logic pin_function_select;
        logic [3:0] dummy_count;
        logic wrap_enable_bit;
        logic [1:0] burst_size;
    } fpd_param_t;

    // Frame decoder states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC = 3'b001,
        ST_DATA = 3'b010,
        ST_READ = 3'b011,
        ST_IGNORE = 3'b100
    } fpd_frame_t;

    // Power states
    typedef enum logic [1:0] {
        PW_ACTIVE = 2'b00,
        PW_ENTER = 2'b01,
        PW_SLEEP = 2'b10,
        PW_EXIT = 2'b11
    } fpd_power_t;

endpackage

// *** hw/fpd_cmd.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpd_cmd #(
    parameter int ADDR_W = 26,
    parameter bit DEDICATED_RESET = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [3:0] dq_i,
    input wire logic qpi_mode_i,
    input wire logic write_enable_latch_i,
    input wire logic work_in_progress_i,
    input wire logic addr_load_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic addr_advance_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe_o,
    output logic sleeping_o,
    output logic latch_clear_o,
    output logic nv_param_wr_o,
    output logic nv_ext_wr_o,
    output logic [7:0] nv_data_o,
    output fpd_pkg::fpd_param_t read_param_o,
    output logic [2:0] drive_strength_o,
    output logic shared_pin_is_reset_o,
    output logic [ADDR_W-1:0] rd_addr_o
);
    import fpd_pkg::*;

    // Local copies of delay counts for the timer and the checks
    localparam int ENTRY_LIM = SLEEP_ENTRY_CYC + 1;
    localparam int EXIT_LIM = SLEEP_EXIT_CYC + 1;
    localparam logic [15:0] ENTRY_CNT = 16'(SLEEP_ENTRY_CYC);
    localparam logic [15:0] EXIT_CNT = 16'(SLEEP_EXIT_CYC);

    logic [5:0] sync1; // First stage, read only by sync2
    logic [5:0] sync2; // {cs_n, sck, dq}
    logic sck_d; // Previous synced clock
    logic cs_d; // Previous synced select
    logic cs_s;
    logic sck_s;
    logic [3:0] dq_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    fpd_frame_t st; // Frame decoder state
    fpd_power_t pw; // Power state
    logic [4:0] cnt; // Bits received, saturating
    logic [7:0] shreg; // Input shift register
    logic [7:0] opc; // Latched opcode
    logic [7:0] out_sh; // Output byte, rotates to repeat
    logic [15:0] pw_timer; // Entry and exit delay counter
    logic [7:0] nv_param; // Persistent parameter copy
    logic [2:0] nv_ods; // Persistent drive strength copy
    logic [4:0] next_cnt;
    logic [7:0] next_sh;
    logic opc_done;
    logic exec;
    logic [7:0] rd_val;
    logic [ADDR_W-1:0] wrap_mask;
    logic [ADDR_W-1:0] next_addr;

    // Two-stage synchroniser for all link pins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Idle link levels: select high, clock low, so no false edge
            sync1 <= 6'h2F;
            sync2 <= 6'h2F;
        end else begin
            sync1 <= {cs_n_i, sck_i, dq_i};
            sync2 <= sync1;
        end
    end

    assign cs_s = sync2[5];
    assign sck_s = sync2[4];
    assign dq_s = sync2[3:0];

    // Edge history of the synced pins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_s;
        end
    end

    // Sample on rising edges, drive on falling edges
    assign sck_rise = !cs_s && sck_s && !sck_d;
    assign sck_fall = !cs_s && !sck_s && sck_d;
    assign cs_rise = cs_s && !cs_d;

    // Next shift value and saturating bit count
    always_comb begin
        next_sh = qpi_mode_i ? {shreg[3:0], dq_s} : {shreg[6:0], dq_s[0]};
        if (cnt > 5'h1B) begin
            next_cnt = 5'h1F;
        end else begin
            next_cnt = cnt + (qpi_mode_i ? 5'h04 : 5'h01);
        end
    end

    assign opc_done = sck_rise && st == ST_OPC && next_cnt == BITS_OPCODE;
    // A command runs only when select rises on an exact byte boundary
    assign exec = cs_rise && st == ST_DATA;

    // Readback source: volatile copies only
    always_comb begin
        if (next_sh == OPC_READ_PARAM) begin
            rd_val = read_param_o;
        end else begin
            rd_val = 8'h00;
            rd_val[EXT_ODS_LSB +: 3] = drive_strength_o;
            rd_val[EXT_BUSY_POS] = work_in_progress_i;
        end
    end

    // Frame decoder
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= ST_IDLE;
            cnt <= 5'h00;
            shreg <= 8'h00;
            opc <= 8'h00;
        end else if (cs_s) begin
            // Deselect ends every frame
            st <= ST_IDLE;
            cnt <= 5'h00;
        end else if (st == ST_IDLE) begin
            st <= ST_OPC;
        end else if (sck_rise) begin
            shreg <= next_sh;
            cnt <= next_cnt;
            if (opc_done) begin
                opc <= next_sh;
                case (pw)
                    PW_ACTIVE: begin
                        case (next_sh)
                            OPC_READ_PARAM, OPC_READ_EXT: begin
                                st <= ST_READ;
                            end
                            OPC_ENTER_SLEEP, OPC_SET_PARAM_NV,
                            OPC_SET_PARAM_V_WE, OPC_SET_PARAM_V,
                            OPC_SET_EXT_NV, OPC_SET_EXT_V: begin
                                st <= ST_DATA;
                            end
                            default: begin
                                st <= ST_IGNORE;
                            end
                        endcase
                    end
                    PW_SLEEP: begin
                        // Only release, and only when idle
                        if (next_sh == OPC_LEAVE_SLEEP &&
                            !work_in_progress_i) begin
                            st <= ST_DATA;
                        end else begin
                            st <= ST_IGNORE;
                        end
                    end
                    default: begin
                        // Entering or recovering: nothing taken
                        st <= ST_IGNORE;
                    end
                endcase
            end else if (st == ST_DATA && next_cnt > BITS_WITH_DATA) begin
                st <= ST_IGNORE;
            end
        end
    end

    // Output shifter, MSB first, repeats while selected
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_sh <= 8'h00;
            dq_o <= 4'h0;
            dq_oe_o <= 4'h0;
        end else if (cs_s) begin
            dq_oe_o <= 4'h0;
        end else if (opc_done) begin
            out_sh <= rd_val;
        end else if (st == ST_READ && sck_fall) begin
            if (qpi_mode_i) begin
                dq_o <= out_sh[7:4];
                dq_oe_o <= 4'hF;
                out_sh <= {out_sh[3:0], out_sh[7:4]};
            end else begin
                dq_o <= {2'b00, out_sh[7], 1'b0};
                dq_oe_o <= 4'h2;
                out_sh <= {out_sh[6:0], out_sh[7]};
            end
        end
    end

    // Power state with entry and exit delays
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pw <= PW_ACTIVE;
            pw_timer <= 16'h0000;
            sleeping_o <= 1'b0;
        end else begin
            case (pw)
                PW_ACTIVE: begin
                    // Exactly one byte framed, else no sleep
                    if (exec && opc == OPC_ENTER_SLEEP &&
                        cnt == BITS_OPCODE) begin
                        pw <= PW_ENTER;
                        pw_timer <= ENTRY_CNT;
                    end
                end
                PW_ENTER: begin
                    if (pw_timer <= 16'h0001) begin
                        pw <= PW_SLEEP;
                        sleeping_o <= 1'b1;
                    end else begin
                        pw_timer <= pw_timer - 16'h0001;
                    end
                end
                PW_SLEEP: begin
                    if (exec && opc == OPC_LEAVE_SLEEP &&
                        cnt == BITS_OPCODE) begin
                        pw <= PW_EXIT;
                        pw_timer <= EXIT_CNT;
                    end
                end
                PW_EXIT: begin
                    // Host must stay deselected here; frames are refused
                    if (pw_timer <= 16'h0001) begin
                        pw <= PW_ACTIVE;
                        sleeping_o <= 1'b0;
                    end else begin
                        pw_timer <= pw_timer - 16'h0001;
                    end
                end
                default: begin
                    pw <= PW_ACTIVE;
                end
            endcase
        end
    end

    // Parameter registers and write strobes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_param_o <= PARAM_RESET;
            nv_param <= PARAM_RESET;
            drive_strength_o <= ODS_RESET;
            nv_ods <= ODS_RESET;
            nv_data_o <= 8'h00;
            nv_param_wr_o <= 1'b0;
            nv_ext_wr_o <= 1'b0;
            latch_clear_o <= 1'b0;
        end else begin
            nv_param_wr_o <= 1'b0;
            nv_ext_wr_o <= 1'b0;
            latch_clear_o <= 1'b0;
            if (pw == PW_ENTER && pw_timer == ENTRY_CNT) begin
                // Sleep reloads the volatile parameter byte, wrap included, from the persistent copy
                read_param_o <= nv_param;
            end else if (exec && pw == PW_ACTIVE &&
                         cnt == BITS_WITH_DATA) begin
                case (opc)
                    OPC_SET_PARAM_NV: begin
                        if (write_enable_latch_i &&
                            !work_in_progress_i) begin
                            nv_param <= shreg;
                            read_param_o <= shreg;
                            nv_data_o <= shreg;
                            nv_param_wr_o <= 1'b1;
                            latch_clear_o <= 1'b1;
                        end
                    end
                    OPC_SET_PARAM_V_WE: begin
                        if (write_enable_latch_i) begin
                            read_param_o <= shreg;
                            latch_clear_o <= 1'b1;
                        end
                    end
                    OPC_SET_PARAM_V: begin
                        read_param_o <= shreg;
                    end
                    OPC_SET_EXT_NV: begin
                        if (write_enable_latch_i &&
                            !work_in_progress_i) begin
                            nv_ods <= shreg[EXT_ODS_LSB +: 3];
                            drive_strength_o <=
                                shreg[EXT_ODS_LSB +: 3];
                            nv_data_o <= shreg;
                            nv_ext_wr_o <= 1'b1;
                            latch_clear_o <= 1'b1;
                        end
                    end
                    OPC_SET_EXT_V: begin
                        drive_strength_o <= shreg[EXT_ODS_LSB +: 3];
                    end
                    default: begin
                        nv_data_o <= nv_data_o;
                    end
                endcase
            end
        end
    end

    // Shared pin role; a dedicated reset pin ignores the select
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shared_pin_is_reset_o <= 1'b0;
        end else begin
            shared_pin_is_reset_o <= !DEDICATED_RESET &&
                read_param_o.pin_function_select;
        end
    end

    // Burst window: size codes 0..3 give 8..64 bytes
    always_comb begin
        wrap_mask = {ADDR_W{1'b1}};
        if (read_param_o.wrap_enable_bit) begin
            wrap_mask = ADDR_W'((8 << read_param_o.burst_size) - 1);
        end
        next_addr = (rd_addr_o & ~wrap_mask) |
            ((rd_addr_o + ADDR_W'(1)) & wrap_mask);
    end

    // Read address generator shared by every read
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_addr_o <= '0;
        end else if (addr_load_i) begin
            rd_addr_o <= addr_i;
        end else if (addr_advance_i) begin
            rd_addr_o <= next_addr;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_exit_hold;
        (pw == PW_EXIT)[*8];
    endsequence

    sequence seq_exit_done;
        ##[1:EXIT_LIM] (pw == PW_ACTIVE);
    endsequence

    chk_sleep_no_write: assert property (
        (pw == PW_SLEEP && $past(pw) == PW_SLEEP) |->
            $stable(read_param_o) && !nv_param_wr_o && !nv_ext_wr_o)
        else $error("register changed while asleep");

    chk_entry_framed: assert property (
        (pw == PW_ENTER && $past(pw) == PW_ACTIVE) |->
            $past(exec && opc == OPC_ENTER_SLEEP && cnt == BITS_OPCODE))
        else $error("sleep entered without framed opcode");

    chk_entry_delay: assert property (
        $rose(pw == PW_ENTER) |-> ##[1:ENTRY_LIM] (pw == PW_SLEEP))
        else $error("sleep entry delay exceeded");

    chk_sleep_ignore: assert property (
        (pw == PW_SLEEP && opc_done && next_sh != OPC_LEAVE_SLEEP) |=>
            (st == ST_IGNORE))
        else $error("opcode accepted while asleep");

    chk_exit_hold: assert property (
        $rose(pw == PW_EXIT) |-> seq_exit_hold ##0 seq_exit_done)
        else $error("exit delay not kept");

    chk_busy_release: assert property (
        (pw == PW_SLEEP && opc_done && work_in_progress_i) |=>
            (st == ST_IGNORE))
        else $error("release taken while busy");

    chk_latch_gate: assert property (
        $rose(nv_param_wr_o) |-> $past(write_enable_latch_i) && latch_clear_o)
        else $error("persistent write without latch");

    chk_nv_mirror: assert property (
        nv_param_wr_o |-> (read_param_o == nv_data_o) &&
            (nv_param == nv_data_o))
        else $error("volatile copy not mirrored");

    chk_wrap_window: assert property (
        (addr_advance_i && !addr_load_i && read_param_o.wrap_enable_bit &&
         $stable(read_param_o)) |=>
            ((rd_addr_o & ~$past(wrap_mask)) ==
             ($past(rd_addr_o) & ~$past(wrap_mask))))
        else $error("wrapped address left burst");

endmodule
`default_nettype wire

// *** verif/fpd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host controller model: frames one command per select window
module fpd_host (
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] dq_o,
    input wire logic [3:0] dq_i
);
    // Half of the 125 ns link period, free of the system clock phase
    localparam real HALF_NS = 62.5;

    // Idle link: select high, serial clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        dq_o = 4'h0;
    end

    // One framed command; nrd bits are read back after the opcode
    task automatic xfer(input logic [15:0] wd, input int nb,
                        input logic qpi, input int nrd,
                        output logic [7:0] rd);
        int i;
        int step;
        step = qpi ? 4 : 1;
        rd = 8'h00;
        cs_n_o = 1'b0;
        // Lead time so the synchroniser sees select before the clock
        #(2 * HALF_NS);
        // MSB first, high nibble first in four-line mode
        for (i = nb - 1; i >= 0; i = i - step) begin
            if (qpi)
                dq_o = wd[i -: 4];
            else
                dq_o = {dq_o[3:1], wd[i]};
            #HALF_NS sck_o = 1'b1;
            #HALF_NS sck_o = 1'b0;
        end
        // Released lines toggle so a stale level never passes
        for (i = 0; i < nrd; i = i + step) begin
            dq_o = ~dq_o;
            #HALF_NS sck_o = 1'b1;
            // Device drives on falls, host samples on rises
            rd = qpi ? {rd[3:0], dq_i} : {rd[6:0], dq_i[1]};
            #HALF_NS sck_o = 1'b0;
        end
        // Select rises only once the last bit of the frame is in
        #HALF_NS cs_n_o = 1'b1;
        dq_o = ~dq_o;
        #250;
    endtask
endmodule
`default_nettype wire

// *** verif/fpd_cmd_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the command block
module fpd_cmd_test;
    import fpd_pkg::*;
    localparam int AW = 26;
    logic clock_i, rst_n_i, qpi, latch, busy, ld, adv, cs_n, sck;
    logic [AW-1:0] addr, rd_addr;
    logic [3:0] host_dq, dev_dq, dev_oe, dq_pin;
    logic sleeping, latch_clr, nvp_wr, nve_wr, pin_rst;
    logic [7:0] nv_data, rb;
    fpd_param_t rparam;
    logic [2:0] ods;
    int fails = 0, samples_checked = 0, clr_n = 0, nvp_n = 0, nve_n = 0;
    logic oe_seen = 1'b0;

    // Shared pins: the driving party wins, else the host's toggle
    assign dq_pin = (dev_oe & dev_dq) | (~dev_oe & host_dq);

    fpd_host fpd_host_i (.cs_n_o(cs_n), .sck_o(sck), .dq_o(host_dq),
        .dq_i(dq_pin));

    fpd_cmd #(.ADDR_W(AW), .DEDICATED_RESET(1'b0)) fpd_cmd_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .sck_i(sck), .dq_i(dq_pin), .qpi_mode_i(qpi),
        .write_enable_latch_i(latch), .work_in_progress_i(busy),
        .addr_load_i(ld), .addr_i(addr), .addr_advance_i(adv),
        .dq_o(dev_dq), .dq_oe_o(dev_oe), .sleeping_o(sleeping),
        .latch_clear_o(latch_clr), .nv_param_wr_o(nvp_wr),
        .nv_ext_wr_o(nve_wr), .nv_data_o(nv_data),
        .read_param_o(rparam), .drive_strength_o(ods),
        .shared_pin_is_reset_o(pin_rst), .rd_addr_o(rd_addr));

    // 125 MHz system clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Pulses last one cycle, so they are counted rather than polled
    always @(negedge clock_i) begin
        if (latch_clr === 1'b1) clr_n++;
        if (nvp_wr === 1'b1) nvp_n++;
        if (nve_wr === 1'b1) nve_n++;
        if (dev_oe !== 4'h0) oe_seen <= 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        // The seen value is copied at the call; this falling edge only paces the checks
        @(negedge clock_i);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp,
                     seen);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Command with data byte, no readback
    task automatic cmd(input logic [7:0] opc, input logic [7:0] d);
        fpd_host_i.xfer({opc, d}, 16, qpi, 0, rb);
    endtask

    // Bare opcode; extra bits model a badly framed command
    task automatic op(input logic [7:0] opc, input int extra);
        fpd_host_i.xfer(16'({opc, 1'b0}) >> (1 - extra), 8 + extra, qpi,
                        0, rb);
    endtask

    task automatic tb_set(input logic w, input logic p, input logic q);
        @(negedge clock_i);
        latch = w;
        busy = p;
        qpi = q;
    endtask

    // Reference next address: aligned bursts of 8, 16, 32, 64 bytes
    function automatic logic [AW-1:0] nxt(logic [AW-1:0] a,
                                          logic [2:0] c);
        int len;
        len = 8 * (2 ** c[1:0]);
        if (!c[2]) return a + 1'b1;
        return AW'(a - a % len + (a % len + 1) % len);
    endfunction

    task automatic t_reset;
        check("param", 32'(rparam), 32'h0);
        check("ods", 32'(ods), 32'h0);
        check("sleep", 32'(sleeping), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_param;
        cmd(OPC_SET_PARAM_V, 8'h04);
        check("c0 write", 32'(rparam), 32'h04);
        check("c0 latch", 32'(clr_n), 32'h0);
        cmd(OPC_SET_PARAM_V_WE, 8'h05);
        check("63 gated", 32'(rparam), 32'h04);
        tb_set(1'b1, 1'b0, 1'b0);
        cmd(OPC_SET_PARAM_V_WE, 8'h06);
        check("63 write", 32'(rparam), 32'h06);
        check("63 latch", 32'(clr_n), 32'h1);
        tb_set(1'b0, 1'b0, 1'b0);
        cmd(OPC_SET_PARAM_NV, 8'h87);
        check("65 gated", 32'(nvp_n), 32'h0);
        tb_set(1'b1, 1'b0, 1'b0);
        cmd(OPC_SET_PARAM_NV, 8'h87);
        check("65 pulse", 32'(nvp_n), 32'h1);
        check("65 data", 32'(nv_data), 32'h87);
        check("65 vol", 32'(rparam), 32'h87);
        check("pin fn", 32'(pin_rst), 32'h1);
        tb_set(1'b0, 1'b0, 1'b0);
        cmd(OPC_SET_PARAM_V, 8'h2D);
        check("pin fn 0", 32'(pin_rst), 32'h0);
        fpd_host_i.xfer({8'h00, OPC_READ_PARAM}, 8, 1'b0, 8, rb);
        check("61 spi", 32'(rb), 32'h2D);
        tb_set(1'b0, 1'b0, 1'b1);
        fpd_host_i.xfer({8'h00, OPC_READ_PARAM}, 8, 1'b1, 8, rb);
        check("61 qpi", 32'(rb), 32'h2D);
        tb_set(1'b0, 1'b0, 1'b0);
        $display("test param done");
    endtask

    task automatic t_wrap;
        logic [AW-1:0] e;
        for (int c = 0; c < 8; c++) begin
            cmd(OPC_SET_PARAM_V, 8'(c));
            e = AW'(26'h12FE);
            @(negedge clock_i);
            ld = 1'b1;
            addr = e;
            @(negedge clock_i);
            ld = 1'b0;
            check("start", 32'(rd_addr), 32'(e));
            for (int k = 0; k < 3; k++) begin
                e = nxt(e, 3'(c));
                adv = 1'b1;
                @(negedge clock_i);
                adv = 1'b0;
                check("step", 32'(rd_addr), 32'(e));
            end
        end
        $display("test wrap done");
    endtask

    task automatic t_ext;
        cmd(OPC_SET_EXT_V, 8'hA0);
        check("83 ods", 32'(ods), 32'h5);
        tb_set(1'b1, 1'b0, 1'b0);
        cmd(OPC_SET_EXT_NV, 8'h60);
        check("85 pulse", 32'(nve_n), 32'h1);
        check("85 data", 32'(nv_data), 32'h60);
        check("85 vol", 32'(ods), 32'h3);
        tb_set(1'b0, 1'b1, 1'b0);
        fpd_host_i.xfer({8'h00, OPC_READ_EXT}, 8, 1'b0, 8, rb);
        check("81 busy", 32'(rb), 32'h61);
        tb_set(1'b0, 1'b0, 1'b0);
        $display("test ext done");
    endtask

    task automatic t_sleep;
        op(OPC_ENTER_SLEEP, 1);
        repeat (SLEEP_ENTRY_CYC) @(posedge clock_i);
        check("long frame", 32'(sleeping), 32'h0);
        tb_set(1'b0, 1'b0, 1'b1);
        op(OPC_ENTER_SLEEP, 0);
        repeat (SLEEP_ENTRY_CYC) @(posedge clock_i);
        check("asleep", 32'(sleeping), 32'h1);
        check("reload", 32'(rparam), 32'h87);
        cmd(OPC_SET_PARAM_V, 8'h04);
        check("asleep wr", 32'(rparam), 32'h87);
        oe_seen = 1'b0;
        fpd_host_i.xfer({8'h00, OPC_READ_PARAM}, 8, 1'b1, 8, rb);
        check("asleep rd", 32'(oe_seen), 32'h0);
        tb_set(1'b0, 1'b1, 1'b1);
        op(OPC_LEAVE_SLEEP, 0);
        repeat (SLEEP_EXIT_CYC) @(posedge clock_i);
        check("busy wake", 32'(sleeping), 32'h1);
        tb_set(1'b0, 1'b0, 1'b1);
        op(OPC_LEAVE_SLEEP, 0);
        check("waking", 32'(sleeping), 32'h1);
        // Select stays high for the whole exit delay
        repeat (SLEEP_EXIT_CYC) @(posedge clock_i);
        check("awake", 32'(sleeping), 32'h0);
        cmd(OPC_SET_PARAM_V, 8'h04);
        check("awake wr", 32'(rparam), 32'h04);
        tb_set(1'b0, 1'b0, 1'b0);
        $display("test sleep done");
    endtask

    // Main sequence: reset for 20 cycles, then each scenario
    initial begin
        rst_n_i = 1'b0;
        {qpi, latch, busy, ld, adv} = 5'h00;
        addr = '0;
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (5) @(negedge clock_i);
        t_reset();
        t_param();
        t_wrap();
        t_ext();
        t_sleep();
        end_sim();
    end

    // Watchdog well past the roughly 64 us the scenarios need
    initial begin
        #600us;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
